// ### pfs_supervisor.sv
// start-up, brownout and overcurrent supervisor of a two-phase boost stage
// assumes sense comparators and pwm requests synchronous to ref_clk_in
//
// Summary of operation
// - load stored configuration before any start decision
// - start needs supply level and mains above brownin
// - begin switching on second qualifying mains peak
// - soft start target follows RC curve, on-time grows
// - without mains, leave brownout after timeout
// - enter brownout after qualified undervoltage delay
// - always stop switching through a soft stop
// - inductor threshold picked by phase count
// - blank inductor overcurrent at each cycle start
// - repeated inductor overcurrent flags shorted coil
// - source overcurrent with own threshold and blanking
// - blank source overcurrent during gate discharge
// - move driver return to ground after turn-off
// - per protection latch, restart, or latch after tries
// - host writes settings over two-wire bus
// - gate pins double as two-wire data and clock
// - restart tracks RC curve, undershoot boost waits
`timescale 1ns/10ps
`include "pfs_cfg.svh"
module pfs_supervisor #(
    parameter int BO_DELAY_CYC = `PFS_BO_DELAY_MS * `PFS_CLK_MHZ * 1000,
    parameter int NOAC_TMO_CYC = `PFS_NOAC_TMO_MS * `PFS_CLK_MHZ * 1000,
    parameter int HOLDOFF_CYC = `PFS_HOLDOFF_MS * `PFS_CLK_MHZ * 1000,
    parameter int SS_STEP_CYC = `PFS_SS_STEP_US * `PFS_CLK_MHZ
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire pfs_pkg::pfs_sense_s sense_in,
    input wire logic [1:0] pwm_in,
    input wire logic two_phase_in,
    output logic [1:0] nvm_addr_out,
    input wire logic [7:0] nvm_data_in,
    input wire logic phase_one_drive_in,
    output logic phase_one_drive_do_out,
    output logic phase_one_drive_oe_out,
    input wire logic phase_two_drive_in,
    output logic phase_two_drive_do_out,
    output logic phase_two_drive_oe_out,
    output logic [1:0] return_gnd_out,
    output logic [7:0] vout_target_out,
    output logic [8:0] ovp_target_out,
    output logic [7:0] ton_limit_out,
    output logic uboost_en_out,
    output logic [9:0] ind_ocp_thresh_out,
    output logic [9:0] src_ocp_thresh_out,
    output pfs_pkg::pfs_status_s status_out
);
    localparam logic [4:0] BLANK_C = 5'((`PFS_BLANK_NS * `PFS_CLK_MHZ + 999) / 1000);
    localparam logic [4:0] DISCH_C = 5'((`PFS_DISCH_NS * `PFS_CLK_MHZ + 999) / 1000);

    pfs_pkg::pfs_state_s s_q;
    pfs_pkg::pfs_state_s s_d;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic sw;
        logic nsw;
        logic [1:0] pr;
        logic blank_any;
        logic ind_hit;
        logic src_hit;
        logic fault;
        logic [1:0] resp;
        logic latch;
        logic step;
        logic [7:0] dl;
        logic scl_r;
        logic scl_f;
        logic i2c_ok;
        sw = 1'b0;
        nsw = 1'b0;
        pr = 2'b00;
        blank_any = 1'b0;
        ind_hit = 1'b0;
        src_hit = 1'b0;
        fault = 1'b0;
        resp = 2'h0;
        latch = 1'b0;
        step = 1'b0;
        dl = 8'h00;
        scl_r = 1'b0;
        scl_f = 1'b0;
        i2c_ok = 1'b0;
        s_d = s_q;
        sw = (s_q.st == pfs_pkg::PFS_SSTART) || (s_q.st == pfs_pkg::PFS_RUN)
            || (s_q.st == pfs_pkg::PFS_SSTOP);
        s_d.thr2 = two_phase_in;
        // overcurrent qualification
        blank_any = (s_q.blank[0] != 5'h00) || (s_q.blank[1] != 5'h00);
        ind_hit = sw && sense_in.ind_ocp_cmp && !blank_any;
        src_hit = sw && sense_in.src_ocp_cmp && !blank_any
            && (s_q.disch[0] == 5'h00) && (s_q.disch[1] == 5'h00);
        pr = pwm_in & ~s_q.pwm_q;
        s_d.pwm_q = pwm_in;
        if (sw && pr[0]) begin
            s_d.streak = s_q.hit ? s_q.streak + 4'h1 : 4'h0;
            s_d.hit = ind_hit;
        end else if (ind_hit) begin
            s_d.hit = 1'b1;
        end
        if (s_q.streak >= `PFS_COIL_CYCLES) begin
            s_d.coil_flt = 1'b1;
            fault = 1'b1;
            resp = s_q.cfg[`PFS_CFG_RESP][1:0];
        end else if (src_hit) begin
            s_d.src_flt = 1'b1;
            fault = 1'b1;
            resp = s_q.cfg[`PFS_CFG_RESP][3:2];
        end
        if (resp == `PFS_RESP_LATCH) begin
            latch = 1'b1;
        end else if (resp == `PFS_RESP_TRIES) begin
            latch = (s_q.tries >= s_q.cfg[`PFS_CFG_TRIES][3:0]);
        end
        // soft start and soft stop stepping
        step = (s_q.tick >= 13'(SS_STEP_CYC - 1));
        s_d.tick = step ? 13'h0000 : s_q.tick + 13'h0001;
        ////////////////////////////////////////////////////////////////////////
        case (s_q.st)
            pfs_pkg::PFS_LOAD: begin
                s_d.cfg[s_q.ld] = nvm_data_in;
                s_d.ld = s_q.ld + 2'h1;
                if (s_q.ld == `PFS_CFG_LAST) begin
                    s_d.st = pfs_pkg::PFS_IDLE;
                end
            end
            pfs_pkg::PFS_IDLE: begin
                if (!sense_in.supply_ok || !sense_in.above_brownin) begin
                    s_d.peaks = 2'h0;
                    s_d.tmr = 26'h0000000;
                end else if ((sense_in.mains_peak && s_q.peaks == 2'h1)
                    || (!sense_in.mains_ac && s_q.tmr >= 26'(NOAC_TMO_CYC - 1))) begin
                    s_d.st = pfs_pkg::PFS_SSTART;
                end else begin
                    if (sense_in.mains_peak) begin
                        s_d.peaks = 2'h1;
                    end
                    s_d.tmr = sense_in.mains_ac ? 26'h0000000 : s_q.tmr + 26'h0000001;
                end
                if (s_d.st == pfs_pkg::PFS_SSTART) begin
                    s_d.lvl = 8'h00;
                    s_d.reached = 1'b0;
                    s_d.tick = 13'h0000;
                    s_d.bo = 26'h0000000;
                    s_d.pend_f = 1'b0;
                    s_d.pend_l = 1'b0;
                    s_d.streak = 4'h0;
                    s_d.hit = 1'b0;
                end
            end
            pfs_pkg::PFS_SSTART, pfs_pkg::PFS_RUN: begin
                if (s_q.st == pfs_pkg::PFS_SSTART && step) begin
                    dl = (`PFS_LVL_FULL - s_q.lvl) >> s_q.cfg[`PFS_CFG_TAU][2:0];
                    s_d.lvl = s_q.lvl + ((dl == 8'h00) ? 8'h01 : dl);
                    if (s_q.lvl >= 8'hFE) begin
                        s_d.lvl = `PFS_LVL_FULL;
                        s_d.st = pfs_pkg::PFS_RUN;
                        s_d.reached = 1'b1;
                    end
                end
                s_d.bo = sense_in.below_brownout ? s_q.bo + 26'h0000001 : 26'h0000000;
                if (fault) begin
                    s_d.lvl = s_q.lvl;
                    s_d.st = pfs_pkg::PFS_SSTOP;
                    s_d.pend_f = 1'b1;
                    s_d.pend_l = latch;
                    if (!latch && resp == `PFS_RESP_TRIES) begin
                        s_d.tries = s_q.tries + 4'h1;
                    end
                    s_d.tick = 13'h0000;
                end else if (sense_in.below_brownout && s_q.bo >= 26'(BO_DELAY_CYC - 1)) begin
                    s_d.lvl = s_q.lvl;
                    s_d.st = pfs_pkg::PFS_SSTOP;
                    s_d.tick = 13'h0000;
                end
            end
            pfs_pkg::PFS_SSTOP: begin
                if (step) begin
                    dl = s_q.lvl >> s_q.cfg[`PFS_CFG_TAU][2:0];
                    s_d.lvl = (s_q.lvl <= 8'h01) ? 8'h00
                        : s_q.lvl - ((dl == 8'h00) ? 8'h01 : dl);
                end
                if (s_q.lvl == 8'h00) begin
                    s_d.tmr = 26'h0000000;
                    s_d.peaks = 2'h0;
                    if (s_q.pend_l) begin
                        s_d.st = pfs_pkg::PFS_LATCHED;
                    end else if (s_q.pend_f) begin
                        s_d.st = pfs_pkg::PFS_HOLD;
                    end else begin
                        s_d.st = pfs_pkg::PFS_IDLE;
                    end
                end
            end
            pfs_pkg::PFS_HOLD: begin
                s_d.tmr = s_q.tmr + 26'h0000001;
                if (s_q.tmr >= 26'(HOLDOFF_CYC - 1)) begin
                    s_d.tmr = 26'h0000000;
                    s_d.st = pfs_pkg::PFS_IDLE;
                end
            end
            default: begin
                s_d.st = pfs_pkg::PFS_LATCHED;
            end
        endcase
        ////////////////////////////////////////////////////////////////////////
        nsw = (s_d.st == pfs_pkg::PFS_SSTART) || (s_d.st == pfs_pkg::PFS_RUN)
            || (s_d.st == pfs_pkg::PFS_SSTOP);
        for (int i = 0; i < 2; i++) begin
            if (pr[i]) begin
                s_d.cut[i] = 1'b0;
            end
            if (ind_hit) begin
                s_d.cut[i] = 1'b1;
            end
            s_d.g[i] = nsw && pwm_in[i] && !s_d.cut[i];
            if (nsw && pr[i]) begin
                s_d.blank[i] = BLANK_C;
            end else if (s_q.blank[i] != 5'h00) begin
                s_d.blank[i] = s_q.blank[i] - 5'h01;
            end
            if (s_q.g[i] && !s_d.g[i]) begin
                s_d.disch[i] = DISCH_C;
            end else if (s_q.disch[i] != 5'h00) begin
                s_d.disch[i] = s_q.disch[i] - 5'h01;
            end
            if (s_d.g[i]) begin
                s_d.rgnd[i] = 1'b0;
            end else if (!s_q.g[i] && s_q.disch[i] <= 5'h01) begin
                s_d.rgnd[i] = 1'b1;
            end
        end
        // two-wire write slave on the gate pins while not switching
        i2c_ok = !sw && !nsw && (s_q.st != pfs_pkg::PFS_LOAD);
        s_d.scl_q = phase_two_drive_in;
        s_d.sda_q = phase_one_drive_in;
        scl_r = phase_two_drive_in && !s_q.scl_q;
        scl_f = !phase_two_drive_in && s_q.scl_q;
        if (!i2c_ok) begin
            s_d.ist = pfs_pkg::PFS_I_IDLE;
            s_d.ack = 1'b0;
        end else if (phase_two_drive_in && s_q.scl_q && s_q.sda_q && !phase_one_drive_in) begin
            s_d.ist = pfs_pkg::PFS_I_ADDR;
            s_d.bitc = 4'h0;
            s_d.ack = 1'b0;
        end else if (phase_two_drive_in && s_q.scl_q && !s_q.sda_q && phase_one_drive_in) begin
            s_d.ist = pfs_pkg::PFS_I_IDLE;
            s_d.ack = 1'b0;
        end else if (s_q.ist != pfs_pkg::PFS_I_IDLE) begin
            if (scl_r && s_q.bitc < 4'h8) begin
                s_d.sh = {s_q.sh[6:0], phase_one_drive_in};
                s_d.bitc = s_q.bitc + 4'h1;
            end else if (scl_f && s_q.ack) begin
                s_d.ack = 1'b0;
                s_d.bitc = 4'h0;
            end else if (scl_f && s_q.bitc == 4'h8) begin
                s_d.ack = 1'b1;
                if (s_q.ist == pfs_pkg::PFS_I_ADDR) begin
                    s_d.ist = pfs_pkg::PFS_I_IDX;
                    if (s_q.sh[7:1] != `PFS_I2C_ADDR || s_q.sh[0]) begin
                        s_d.ist = pfs_pkg::PFS_I_IDLE;
                        s_d.ack = 1'b0;
                    end
                end else if (s_q.ist == pfs_pkg::PFS_I_IDX) begin
                    s_d.ptr = s_q.sh[1:0];
                    s_d.ist = pfs_pkg::PFS_I_DATA;
                end else begin
                    s_d.cfg[s_q.ptr] = s_q.sh;
                    s_d.ptr = s_q.ptr + 2'h1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign nvm_addr_out = s_q.ld;
    assign phase_one_drive_do_out = s_q.g[0];
    assign phase_one_drive_oe_out = s_q.g[0] || s_q.rgnd[0] == 1'b0 || s_q.ack
        || (s_q.st inside {pfs_pkg::PFS_SSTART, pfs_pkg::PFS_RUN, pfs_pkg::PFS_SSTOP});
    assign phase_two_drive_do_out = s_q.g[1];
    assign phase_two_drive_oe_out = s_q.g[1]
        || (s_q.st inside {pfs_pkg::PFS_SSTART, pfs_pkg::PFS_RUN, pfs_pkg::PFS_SSTOP});
    assign return_gnd_out = s_q.rgnd;
    assign vout_target_out = s_q.lvl;
    assign ovp_target_out = {1'b0, s_q.lvl} + {1'b0, s_q.cfg[`PFS_CFG_OVPM]};
    assign ton_limit_out = (s_q.lvl < `PFS_TON_MIN) ? `PFS_TON_MIN : s_q.lvl;
    assign uboost_en_out = s_q.reached;
    assign ind_ocp_thresh_out = s_q.thr2 ? `PFS_IND_OCP_2PH : `PFS_IND_OCP_1PH;
    assign src_ocp_thresh_out = `PFS_SRC_OCP;
    assign status_out = '{state: s_q.st, coil_fault: s_q.coil_flt, src_fault: s_q.src_flt,
        reached: s_q.reached, tries: s_q.tries};

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_load_first: assert property ((s_q.st == pfs_pkg::PFS_LOAD) |=>
        (s_q.st inside {pfs_pkg::PFS_LOAD, pfs_pkg::PFS_IDLE})) else $error("left load early");
    a_start_conds: assert property ($rose(s_q.st == pfs_pkg::PFS_SSTART) |->
        $past(sense_in.supply_ok && sense_in.above_brownin)) else $error("bad start");
    a_first_peak: assert property ((s_q.st == pfs_pkg::PFS_IDLE && s_q.peaks == 2'h0
        && sense_in.mains_ac && sense_in.mains_peak) |=> (s_q.st == pfs_pkg::PFS_IDLE))
        else $error("started on first peak");
    a_ss_rise: assert property ((s_q.st == pfs_pkg::PFS_SSTART) |=>
        (s_q.lvl >= $past(s_q.lvl))) else $error("soft start fell");
    a_bo_qualify: assert property ((s_q.st inside {pfs_pkg::PFS_SSTART, pfs_pkg::PFS_RUN}
        && !sense_in.below_brownout) |=> !(s_q.st == pfs_pkg::PFS_SSTOP && !s_q.pend_f))
        else $error("brownout without delay");
    a_soft_stop: assert property ((s_q.st == pfs_pkg::PFS_SSTOP && s_q.lvl != 8'h00) |=>
        (s_q.st == pfs_pkg::PFS_SSTOP)) else $error("soft stop cut short");
    a_ind_blank: assert property (((s_q.blank[0] != 5'h00 || s_q.blank[1] != 5'h00)
        && s_q.cut == 2'b00) |=> (s_q.cut == 2'b00)) else $error("ocp in blanking");
    a_src_disch: assert property ((s_q.disch[0] != 5'h00 || s_q.disch[1] != 5'h00) |=>
        !$rose(s_q.src_flt)) else $error("source ocp in discharge");
    a_ret_gnd: assert property (s_q.rgnd[0] |->
        (!phase_one_drive_do_out && s_q.disch[0] == 5'h00)) else $error("ground return too early");
    a_gates_idle: assert property (!(s_q.st inside {pfs_pkg::PFS_SSTART, pfs_pkg::PFS_RUN,
        pfs_pkg::PFS_SSTOP}) |-> (!phase_one_drive_do_out && !phase_two_drive_do_out)) else $error("gate active");
    a_uboost_off: assert property ((s_q.st == pfs_pkg::PFS_SSTART) |->
        !uboost_en_out) else $error("undershoot boost early");

    c_run: cover property (s_q.st == pfs_pkg::PFS_RUN);
    c_brownout: cover property ($rose(s_q.st == pfs_pkg::PFS_SSTOP) && !s_q.pend_f);
    c_latched: cover property (s_q.st == pfs_pkg::PFS_LATCHED);
    c_i2c_write: cover property (s_q.ist == pfs_pkg::PFS_I_DATA && s_q.ack);
endmodule : pfs_supervisor

// ### pfs_cfg.svh
// constants of the start-up, brownout and overcurrent supervisor
// assumes a 50 MHz system clock; included by the design and the testbench
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
`define PFS_CLK_MHZ 50
`define PFS_BLANK_NS 300
`define PFS_DISCH_NS 200
`define PFS_BO_DELAY_MS 50
`define PFS_NOAC_TMO_MS 500
`define PFS_HOLDOFF_MS 1000
`define PFS_SS_STEP_US 100
`define PFS_COIL_CYCLES 4'h4
`define PFS_I2C_ADDR 7'h38
`define PFS_CFG_TAU 2'h0
`define PFS_CFG_RESP 2'h1
`define PFS_CFG_TRIES 2'h2
`define PFS_CFG_OVPM 2'h3
`define PFS_CFG_LAST 2'h3
`define PFS_RESP_LATCH 2'h0
`define PFS_RESP_RESTART 2'h1
`define PFS_RESP_TRIES 2'h2
`define PFS_IND_OCP_1PH 10'h36A
`define PFS_IND_OCP_2PH 10'h2D4
`define PFS_SRC_OCP 10'h07D
`define PFS_TON_MIN 8'h08
`define PFS_LVL_FULL 8'hFF
`endif

// ### pfs_pkg.sv
// types of the start-up, brownout and overcurrent supervisor
// assumes pfs_cfg.svh is on the include path
package pfs_pkg;
    typedef enum logic [2:0] {
        PFS_LOAD, PFS_IDLE, PFS_SSTART, PFS_RUN, PFS_SSTOP, PFS_HOLD, PFS_LATCHED
    } pfs_state_e;
    typedef enum logic [1:0] {PFS_I_IDLE, PFS_I_ADDR, PFS_I_IDX, PFS_I_DATA} pfs_i2c_e;
    typedef struct packed {
        logic supply_ok;
        logic above_brownin;
        logic below_brownout;
        logic mains_peak;
        logic mains_ac;
        logic ind_ocp_cmp;
        logic src_ocp_cmp;
    } pfs_sense_s;
    typedef struct packed {
        pfs_state_e state;
        logic coil_fault;
        logic src_fault;
        logic reached;
        logic [3:0] tries;
    } pfs_status_s;
    typedef struct packed {
        pfs_state_e st;
        logic [3:0][7:0] cfg;
        logic [1:0] ld;
        logic [1:0] peaks;
        logic [25:0] tmr;
        logic [25:0] bo;
        logic [12:0] tick;
        logic [7:0] lvl;
        logic reached;
        logic [3:0] tries;
        logic pend_f;
        logic pend_l;
        logic coil_flt;
        logic src_flt;
        logic thr2;
        logic [1:0] pwm_q;
        logic [1:0] g;
        logic [1:0] cut;
        logic [1:0] rgnd;
        logic [1:0][4:0] blank;
        logic [1:0][4:0] disch;
        logic hit;
        logic [3:0] streak;
        logic scl_q;
        logic sda_q;
        pfs_i2c_e ist;
        logic [3:0] bitc;
        logic [7:0] sh;
        logic [1:0] ptr;
        logic ack;
    } pfs_state_s;
endpackage : pfs_pkg

// ### pfs_stage_model.sv
// analog stage model: stored config memory and gate pin levels
// assumes the supervisor's nvm read port and split gate pins
`timescale 1ns/10ps
module pfs_stage_model (
    input wire logic [1:0] nvm_addr_in,
    output logic [7:0] nvm_data_out,
    input wire logic [1:0] do_in,
    input wire logic [1:0] oe_in,
    input wire logic host_mode_in,
    input wire logic [1:0] host_in,
    output logic [1:0] pin_out
);
    ////////////////////////////////////////////////////////////////////////
    // tau 2, coil restart, source latch, two tries, margin 0x10
    logic [3:0][7:0] mem;
    assign mem = {8'h10, 8'h02, 8'h01, 8'h02};
    assign nvm_data_out = mem[nvm_addr_in];
    // released pin: pull-down while switching, host pull-up when programming
    assign pin_out[0] = oe_in[0] ? do_in[0] : (host_mode_in & host_in[0]);
    assign pin_out[1] = oe_in[1] ? do_in[1] : (host_mode_in & host_in[1]);
endmodule : pfs_stage_model

// ### pfs_supervisor_tb.sv
// testbench of the start-up, brownout and overcurrent supervisor
// assumes pfs_pkg, pfs_cfg.svh and pfs_stage_model are compiled first
`timescale 1ns/10ps
`include "pfs_cfg.svh"
module pfs_supervisor_tb;
    logic ref_clk;
    logic rst_n;
    pfs_pkg::pfs_sense_s sense;
    logic [1:0] pwm;
    logic two_ph;
    logic [1:0] nvm_addr;
    logic [7:0] nvm_data;
    logic [1:0] pin;
    logic [1:0] dout;
    logic [1:0] oe;
    logic host_mode;
    logic [1:0] host;
    logic [1:0] rgnd;
    logic [7:0] tgt;
    logic [8:0] ovp;
    logic [7:0] ton;
    logic ub;
    logic [9:0] ithr;
    logic [9:0] sthr;
    pfs_pkg::pfs_status_s status;
    int err_count, checked, i, steps;
    logic [7:0] prev;
    ////////////////////////////////////////////////////////////////////////
    pfs_supervisor #(.BO_DELAY_CYC(20), .NOAC_TMO_CYC(40), .HOLDOFF_CYC(30),
        .SS_STEP_CYC(2)) u_pfs_supervisor (.ref_clk_in(ref_clk), .rst_n_in(rst_n),
        .sense_in(sense), .pwm_in(pwm), .two_phase_in(two_ph), .nvm_addr_out(nvm_addr),
        .nvm_data_in(nvm_data), .phase_one_drive_in(pin[0]), .phase_one_drive_do_out(dout[0]),
        .phase_one_drive_oe_out(oe[0]), .phase_two_drive_in(pin[1]), .phase_two_drive_do_out(dout[1]),
        .phase_two_drive_oe_out(oe[1]), .return_gnd_out(rgnd), .vout_target_out(tgt),
        .ovp_target_out(ovp), .ton_limit_out(ton), .uboost_en_out(ub),
        .ind_ocp_thresh_out(ithr), .src_ocp_thresh_out(sthr), .status_out(status));
    pfs_stage_model u_pfs_stage_model (.nvm_addr_in(nvm_addr), .nvm_data_out(nvm_data),
        .do_in(dout), .oe_in(oe), .host_mode_in(host_mode), .host_in(host),
        .pin_out(pin));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : tick
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_count++;
        end
    endtask : chk
    task automatic chk_st(input pfs_pkg::pfs_state_e s);
        chk("state", {7'h0, s}, {7'h0, status.state});
    endtask : chk_st
    task automatic wait_st(input pfs_pkg::pfs_state_e s, input int lim);
        int j;
        for (j = 0; j < lim && status.state !== s; j++) tick(1);
        chk_st(s);
        if (status.state !== s) tally_and_finish();
    endtask : wait_st
    task automatic peak();
        sense.mains_peak <= 1'b1;
        tick(1);
        sense.mains_peak <= 1'b0;
        tick(1);
    endtask : peak
    task automatic i2c_start();
        host[0] <= 1'b0;
        tick(4);
        host[1] <= 1'b0;
        tick(4);
    endtask : i2c_start
    task automatic i2c_stop();
        host[0] <= 1'b0;
        tick(4);
        host[1] <= 1'b1;
        tick(4);
        host[0] <= 1'b1;
        tick(4);
    endtask : i2c_stop
    task automatic i2c_byte(input logic [7:0] b, input logic nack);
        int k;
        for (k = 7; k >= 0; k--) begin
            host[0] <= b[k];
            tick(4);
            host[1] <= 1'b1;
            tick(4);
            host[1] <= 1'b0;
        end
        host[0] <= 1'b1;
        tick(4);
        host[1] <= 1'b1;
        tick(2);
        chk("ack", {9'h0, nack}, {9'h0, pin[0]});
        tick(2);
        host[1] <= 1'b0;
        tick(4);
    endtask : i2c_byte
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        sense = '0;
        sense.mains_ac = 1'b1;
        pwm = 2'h0;
        two_ph = 1'b0;
        host_mode = 1'b0;
        host = 2'h3;
        err_count = 0;
        checked = 0;
        tick(3);
        chk_st(pfs_pkg::PFS_LOAD);
        chk("g1 do", 10'h0, {9'h0, dout[0]});
        rst_n <= 1'b1;
        tick(3);
        chk_st(pfs_pkg::PFS_LOAD);
        tick(1);
        chk_st(pfs_pkg::PFS_IDLE);
        chk("ovp", 10'h010, {1'b0, ovp});
        pwm <= 2'h3;
        sense.above_brownin <= 1'b1;
        peak();
        peak();
        tick(3);
        chk_st(pfs_pkg::PFS_IDLE);
        chk("g2 oe", 10'h0, {9'h0, oe[1]});
        chk("g1 do", 10'h0, {9'h0, dout[0]});
        pwm <= 2'h0;
        sense.supply_ok <= 1'b1;
        peak();
        tick(3);
        chk_st(pfs_pkg::PFS_IDLE);
        peak();
        wait_st(pfs_pkg::PFS_SSTART, 3);
        prev = 8'h00;
        steps = 0;
        for (i = 0; i < 300 && status.state === pfs_pkg::PFS_SSTART; i++) begin
            chk("ovp", {2'h0, tgt} + 10'h010, {1'b0, ovp});
            chk("ub", 10'h0, {9'h0, ub});
            chk("ton", (tgt < 8'h08) ? 10'h008 : {2'h0, tgt}, {2'h0, ton});
            chk("rise", 10'h1, {9'h0, tgt >= prev});
            if (tgt != prev) steps++;
            prev = tgt;
            tick(1);
        end
        wait_st(pfs_pkg::PFS_RUN, 2);
        chk("steps", 10'h1, {9'h0, steps > 3});
        chk("tgt", 10'h0FF, {2'h0, tgt});
        chk("reach", 10'h1, {9'h0, status.reached});
        tick(1);
        chk("ub", 10'h1, {9'h0, ub});
        two_ph <= 1'b1;
        tick(2);
        chk("ithr", `PFS_IND_OCP_2PH, ithr);
        two_ph <= 1'b0;
        tick(2);
        chk("ithr", `PFS_IND_OCP_1PH, ithr);
        chk("sthr", `PFS_SRC_OCP, sthr);
        sense.below_brownout <= 1'b1;
        tick(15);
        sense.below_brownout <= 1'b0;
        tick(2);
        sense.below_brownout <= 1'b1;
        tick(18);
        chk_st(pfs_pkg::PFS_RUN);
        wait_st(pfs_pkg::PFS_SSTOP, 6);
        chk("soft", 10'h1, {9'h0, tgt > 8'h80});
        sense.below_brownout <= 1'b0;
        wait_st(pfs_pkg::PFS_IDLE, 300);
        chk("g2 oe", 10'h0, {9'h0, oe[1]});
        sense.mains_ac <= 1'b0;
        tick(30);
        chk_st(pfs_pkg::PFS_IDLE);
        wait_st(pfs_pkg::PFS_SSTART, 15);
        sense.mains_ac <= 1'b1;
        wait_st(pfs_pkg::PFS_RUN, 300);
        pwm <= 2'h1;
        tick(1);
        chk("g1 do", 10'h1, {9'h0, dout[0]});
        chk("rgnd", 10'h0, {9'h0, rgnd[0]});
        tick(3);
        sense.ind_ocp_cmp <= 1'b1;
        tick(1);
        sense.ind_ocp_cmp <= 1'b0;
        tick(2);
        chk("g1 do", 10'h1, {9'h0, dout[0]});
        tick(14);
        sense.ind_ocp_cmp <= 1'b1;
        tick(1);
        sense.ind_ocp_cmp <= 1'b0;
        tick(1);
        chk("g1 do", 10'h0, {9'h0, dout[0]});
        sense.src_ocp_cmp <= 1'b1;
        tick(1);
        sense.src_ocp_cmp <= 1'b0;
        pwm <= 2'h0;
        tick(14);
        chk("rgnd", 10'h1, {9'h0, rgnd[0]});
        chk("src f", 10'h0, {9'h0, status.src_fault});
        for (i = 0; i < 4; i++) begin
            pwm <= 2'h1;
            tick(18);
            sense.ind_ocp_cmp <= 1'b1;
            tick(1);
            sense.ind_ocp_cmp <= 1'b0;
            pwm <= 2'h0;
            tick(12);
        end
        chk("coil f", 10'h1, {9'h0, status.coil_fault});
        wait_st(pfs_pkg::PFS_HOLD, 300);
        chk("g1 do", 10'h0, {9'h0, dout[0]});
        tick(20);
        chk_st(pfs_pkg::PFS_HOLD);
        wait_st(pfs_pkg::PFS_IDLE, 15);
        host_mode <= 1'b1;
        tick(4);
        i2c_start();
        i2c_byte(8'h72, 1'b1);
        i2c_stop();
        i2c_start();
        i2c_byte({`PFS_I2C_ADDR, 1'b0}, 1'b0);
        i2c_byte(8'h03, 1'b0);
        i2c_byte(8'h20, 1'b0);
        i2c_stop();
        host_mode <= 1'b0;
        tick(4);
        chk("ovp", 10'h020, {1'b0, ovp});
        peak();
        peak();
        wait_st(pfs_pkg::PFS_RUN, 300);
        pwm <= 2'h3;
        tick(18);
        chk("g2 do", 10'h1, {9'h0, dout[1]});
        sense.src_ocp_cmp <= 1'b1;
        tick(1);
        sense.src_ocp_cmp <= 1'b0;
        tick(1);
        chk("src f", 10'h1, {9'h0, status.src_fault});
        pwm <= 2'h0;
        wait_st(pfs_pkg::PFS_LATCHED, 300);
        peak();
        peak();
        tick(4);
        chk_st(pfs_pkg::PFS_LATCHED);
        chk("g1 do", 10'h0, {9'h0, dout[0]});
        rst_n <= 1'b0;
        tick(2);
        chk_st(pfs_pkg::PFS_LOAD);
        rst_n <= 1'b1;
        wait_st(pfs_pkg::PFS_IDLE, 6);
        chk("tries", 10'h0, {6'h0, status.tries});
        host_mode <= 1'b1;
        tick(4);
        i2c_start();
        i2c_byte({`PFS_I2C_ADDR, 1'b0}, 1'b0);
        i2c_byte(8'h01, 1'b0);
        i2c_byte(8'h08, 1'b0);
        i2c_byte(8'h01, 1'b0);
        i2c_stop();
        host_mode <= 1'b0;
        for (i = 0; i < 2; i++) begin
            wait_st(pfs_pkg::PFS_IDLE, 120);
            peak();
            peak();
            wait_st(pfs_pkg::PFS_RUN, 300);
            pwm <= 2'h1;
            tick(18);
            sense.src_ocp_cmp <= 1'b1;
            tick(1);
            sense.src_ocp_cmp <= 1'b0;
            pwm <= 2'h0;
            chk("tries", 10'h1, {6'h0, status.tries});
        end
        wait_st(pfs_pkg::PFS_LATCHED, 300);
        tally_and_finish();
    end
endmodule : pfs_supervisor_tb
